/* File: rtl/agb_defs.svh */
/*
  agb_defs.svh: offsets, field positions, reset values and widths for the
  address generation block.
  assumes: included by its bare name from the rtl module only.
*/
`ifndef AGB_DEFS_SVH
`define AGB_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the ahb-lite slave)
// ----------------------------------------------------------------------
`define AGB_OFF_MODCTL   8'h00
`define AGB_OFF_BRCTL    8'h04
`define AGB_OFF_TABLE_PAGE   8'h08
`define AGB_OFF_VISPAG   8'h0c
`define AGB_OFF_STATUS   8'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define AGB_XSEL_LSB     0
`define AGB_YSEL_LSB     4
`define AGB_BRSEL_LSB    8
`define AGB_Y_MODULO_ENABLE_BIT   14
`define AGB_X_MODULO_ENABLE_BIT   15
`define AGB_BITREV_ENABLE_BIT     15
`define AGB_CFGSEL_BIT   7
`define AGB_VIEW_BIT     0

// ----------------------------------------------------------------------
// reset values and fixed codes
// ----------------------------------------------------------------------
`define AGB_MODCTL_RST   16'h0fff
`define AGB_BRCTL_RST    16'h0000
`define AGB_PAGE_RST     8'h00
`define AGB_SEL_OFF      4'hf
`define AGB_BRBUF_BITS   4

`endif

/* File: rtl/agb_pkg.sv */
/*
  agb_pkg.sv: types shared by the address generation block.
  assumes: nothing beyond agb_defs.svh.
*/
`default_nettype none

package agb_pkg;

  // addressing mode of one access
  typedef enum logic [2:0] {
    AGB_MODE_DIRECT   = 3'h0,
    AGB_MODE_IND      = 3'h1,
    AGB_MODE_POST_INC = 3'h2,
    AGB_MODE_POST_DEC = 3'h3,
    AGB_MODE_PRE_INC  = 3'h4,
    AGB_MODE_PRE_DEC  = 3'h5,
    AGB_MODE_REG_OFS  = 3'h6,
    AGB_MODE_LIT_OFS  = 3'h7
  } agb_mode_t;

  // kind of program space access
  typedef enum logic [1:0] {
    AGB_PA_NONE  = 2'h0,
    AGB_PA_TBL   = 2'h1,
    AGB_PA_VIEW  = 2'h2,
    AGB_PA_FETCH = 2'h3
  } agb_pacc_t;

  // bus slave data phase state, one-hot
  typedef enum logic [1:0] {
    AGB_BS_IDLE = 2'b01,
    AGB_BS_DATA = 2'b10
  } agb_bstate_t;

endpackage

`default_nettype wire

/* File: rtl/agb_addr_gen.sv */
/*
  agb_addr_gen.sv: x/y effective address generation with modulo and
  bit-reversed correction, program space address forming and table read
  data mapping, with an ahb-lite slave for the control registers.
  assumes: one clock, synchronous active-low reset, the pipeline presents
  one request per cycle on REQ_VALID_I, same-domain inputs.
*/
// Operation
// - modulo check wraps addresses strictly beyond a boundary, not only equal.
// - corrected pointer written back only for pre or post modify modes.
// - bit reversal only in x write generator, never reads or y.
// - only the modifier is bit reversed, addresses stay normal order.
// - bit reversal needs select not 15, enable set, pre/post increment.
// - a 15-bit bit-reverse modifier field is held.
// - bit reversed addresses are word addresses, modifier scaled to bytes.
// - byte accesses or other modes get ordinary addresses.
// - pointer plus modifier, normal offset ignored, address bit 0 cleared.
// - bit reversal beats modulo in x write; x read keeps modulo.
// - 16-entry buffer yields mirrored index sequence.
// - program space 24 bits, data space 16 bits.
// - table address is table page above full 16-bit address.
// - table page top bit selects user or configuration memory.
// - view access joins view page with low 15 bits, 23-bit address.
// - view: data bit 15 ignored, bit 15 from page bit 0, bit 23 zero.
// - view access is read-only and returns low program word only.
// - program counter advances by two per program word.
// - low table read: word, or byte picked by byte select.
// - high table read: upper byte always zero, phantom byte reads zero.
// - modulo active only with select not 15 and enable set.
`timescale 1ns/10ps
`include "agb_defs.svh"
`default_nettype none

module agb_addr_gen (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  // ahb-lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  // effective address request
  input  wire logic        REQ_VALID_I,
  input  wire logic        REQ_X_SPACE_I,
  input  wire logic        REQ_WRITE_I,
  input  wire logic        REQ_BYTE_I,
  input  wire logic [2:0]  REQ_MODE_I,
  input  wire logic [3:0]  REQ_PTR_SEL_I,
  input  wire logic [15:0] REQ_PTR_I,
  input  wire logic [15:0] REQ_OFFSET_I,
  input  wire logic [15:0] MOD_START_I,
  input  wire logic [15:0] MOD_END_I,
  output logic      [15:0] EA_O,
  output logic      [15:0] PTR_NEXT_O,
  output logic             PTR_WB_O,
  output logic             BITREV_ACTIVE_O,
  output logic             MOD_WRAP_O,
  // program space address forming
  input  wire logic [1:0]  PACC_I,
  input  wire logic [15:0] PACC_EA_I,
  input  wire logic        PACC_WRITE_I,
  input  wire logic        VIEW_ON_I,
  input  wire logic [22:0] PC_I,
  input  wire logic        PC_STEP_I,
  output logic      [23:0] PROG_ADDR_O,
  output logic             PROG_CFG_O,
  output logic             PROG_VALID_O,
  output logic             VIEW_REFUSED_O,
  output logic      [22:0] PC_NEXT_O,
  // table read data mapping
  input  wire logic        TRD_VALID_I,
  input  wire logic        TRD_HIGH_I,
  input  wire logic        TRD_BYTE_I,
  input  wire logic        TRD_BSEL_I,
  input  wire logic [23:0] PROG_WORD_I,
  output logic      [15:0] TRD_DATA_O
);

  // --------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------

  // reversed-carry add over the low buffer bits of a word address
  function automatic logic [15:0] rev_add(input logic [15:0] a, input logic [15:0] m);
    logic [15:0] ra;
    logic [15:0] rm;
    logic [15:0] rs;
    ra = '0;
    rm = '0;
    for (int i = 0; i < 16; i++) begin
      ra[i] = a[15 - i];
      rm[i] = m[15 - i];
    end
    rs = ra + rm;
    for (int i = 0; i < 16; i++) begin
      a[i] = rs[15 - i];
    end
    return a;
  endfunction

  // pointer select is a real pointer and the feature bit is set
  function automatic logic sel_on(input logic [3:0] sel, input logic en);
    return (sel != `AGB_SEL_OFF) && en;
  endfunction

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic [15:0]              modctl_q;
  logic [15:0]              brctl_q;
  logic [7:0]               table_page_q;
  logic [7:0]               vispag_q;
  agb_pkg::agb_bstate_t     bs_q;
  logic [7:0]               baddr_q;
  logic                     bwr_q;
  logic                     view_ref_seen_q;

  wire logic bus_req = HSEL_I && HREADY_I && HTRANS_I[1];

  // bus slave address phase capture, zero wait states
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      bs_q    <= agb_pkg::AGB_BS_IDLE;
      baddr_q <= 8'h00;
      bwr_q   <= 1'b0;
    end else begin
      bs_q    <= bus_req ? agb_pkg::AGB_BS_DATA : agb_pkg::AGB_BS_IDLE;
      baddr_q <= HADDR_I[7:0];
      bwr_q   <= bus_req && HWRITE_I;
    end
  end

  // register writes in the data phase
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      modctl_q <= `AGB_MODCTL_RST;
      brctl_q  <= `AGB_BRCTL_RST;
      table_page_q <= `AGB_PAGE_RST;
      vispag_q <= `AGB_PAGE_RST;
    end else if (bs_q == agb_pkg::AGB_BS_DATA && bwr_q) begin
      case (baddr_q)
        `AGB_OFF_MODCTL: modctl_q <= HWDATA_I[15:0];
        `AGB_OFF_BRCTL:  brctl_q  <= HWDATA_I[15:0]; // 15-bit modifier
        `AGB_OFF_TABLE_PAGE: table_page_q <= HWDATA_I[7:0];
        `AGB_OFF_VISPAG: vispag_q <= HWDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // read data for the next data phase, unmapped reads give zero
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (bus_req && !HWRITE_I) begin
      case (HADDR_I[7:0])
        `AGB_OFF_MODCTL: HRDATA_O <= {16'h0000, modctl_q};
        `AGB_OFF_BRCTL:  HRDATA_O <= {16'h0000, brctl_q};
        `AGB_OFF_TABLE_PAGE: HRDATA_O <= {24'h000000, table_page_q};
        `AGB_OFF_VISPAG: HRDATA_O <= {24'h000000, vispag_q};
        `AGB_OFF_STATUS: HRDATA_O <= {29'h0, view_ref_seen_q, MOD_WRAP_O, BITREV_ACTIVE_O};
        default:         HRDATA_O <= 32'h0000_0000;
      endcase
    end else begin
      HRDATA_O <= 32'h0000_0000;
    end
  end

  // ready once out of reset (low while reset is held), always okay
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      HREADYOUT_O <= 1'b0;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // effective address generation
  // --------------------------------------------------------------------
  wire logic [3:0]  xsel   = modctl_q[`AGB_XSEL_LSB +: 4];
  wire logic [3:0]  ysel   = modctl_q[`AGB_YSEL_LSB +: 4];
  wire logic [3:0]  brsel  = modctl_q[`AGB_BRSEL_LSB +: 4];
  wire logic [14:0] br_mod = brctl_q[14:0];

  logic [15:0] step;
  logic [15:0] ea_raw;
  logic [15:0] ptr_raw;
  logic [15:0] ea_c;
  logic [15:0] ptr_c;
  logic        wb_c;
  logic        br_c;
  logic        mod_c;
  logic        wrap_c;
  logic        pre_m;
  logic        post_m;
  logic        inc_m;

  // modulo correction of one address, strict beyond test
  function automatic logic [16:0] mod_fix(input logic [15:0] a, input logic [15:0] s,
                                          input logic [15:0] e);
    if (a > e)
      return {1'b1, 16'(a - e - 16'h0001 + s)};
    else if (a < s)
      return {1'b1, 16'(e - (s - a) + 16'h0001)};
    else
      return {1'b0, a};
  endfunction

  // combinational address forming
  always_comb begin
    logic [16:0] fe;
    logic [16:0] fp;
    fe     = '0;
    fp     = '0;
    inc_m  = (REQ_MODE_I == agb_pkg::AGB_MODE_PRE_INC) ||
             (REQ_MODE_I == agb_pkg::AGB_MODE_POST_INC);
    pre_m  = (REQ_MODE_I == agb_pkg::AGB_MODE_PRE_INC) ||
             (REQ_MODE_I == agb_pkg::AGB_MODE_PRE_DEC);
    post_m = (REQ_MODE_I == agb_pkg::AGB_MODE_POST_INC) ||
             (REQ_MODE_I == agb_pkg::AGB_MODE_POST_DEC);
    step   = REQ_BYTE_I ? 16'h0001 : 16'h0002;
    // bit reversal only on x word writes through the chosen pointer
    br_c   = sel_on(brsel, brctl_q[`AGB_BITREV_ENABLE_BIT]) && REQ_X_SPACE_I && REQ_WRITE_I &&
             !REQ_BYTE_I && inc_m && (REQ_PTR_SEL_I == brsel);
    // modulo per space, off in x write while reversing
    mod_c  = REQ_X_SPACE_I ?
             (sel_on(xsel, modctl_q[`AGB_X_MODULO_ENABLE_BIT]) && REQ_PTR_SEL_I == xsel) :
             (sel_on(ysel, modctl_q[`AGB_Y_MODULO_ENABLE_BIT]) && REQ_PTR_SEL_I == ysel);
    if (br_c)
      mod_c = 1'b0;
    ptr_raw = REQ_PTR_I;
    ea_raw  = REQ_PTR_I;
    wb_c    = 1'b0;
    case (REQ_MODE_I)
      agb_pkg::AGB_MODE_POST_INC: begin
        ptr_raw = 16'(REQ_PTR_I + step);
        wb_c    = 1'b1;
      end
      agb_pkg::AGB_MODE_POST_DEC: begin
        ptr_raw = 16'(REQ_PTR_I - step);
        wb_c    = 1'b1;
      end
      agb_pkg::AGB_MODE_PRE_INC: begin
        ptr_raw = 16'(REQ_PTR_I + step);
        ea_raw  = ptr_raw;
        wb_c    = 1'b1;
      end
      agb_pkg::AGB_MODE_PRE_DEC: begin
        ptr_raw = 16'(REQ_PTR_I - step);
        ea_raw  = ptr_raw;
        wb_c    = 1'b1;
      end
      agb_pkg::AGB_MODE_REG_OFS,
      agb_pkg::AGB_MODE_LIT_OFS: ea_raw = 16'(REQ_PTR_I + REQ_OFFSET_I);
      default: ;
    endcase
    ea_c   = ea_raw;
    ptr_c  = ptr_raw;
    wrap_c = 1'b0;
    if (br_c) begin
      // pointer plus reversed-carry scaled modifier, offset ignored
      ptr_c = rev_add({REQ_PTR_I[15:1], 1'b0}, {br_mod, 1'b0});
      ptr_c[0] = 1'b0;
      ea_c = (REQ_MODE_I == agb_pkg::AGB_MODE_PRE_INC) ? ptr_c : {REQ_PTR_I[15:1], 1'b0};
    end else if (mod_c) begin
      fe     = mod_fix(ea_raw, MOD_START_I, MOD_END_I);
      fp     = mod_fix(ptr_raw, MOD_START_I, MOD_END_I);
      ea_c   = fe[15:0];
      ptr_c  = fp[15:0];
      wrap_c = fe[16] || (wb_c && fp[16]);
    end
    if (!(pre_m || post_m))
      ptr_c = REQ_PTR_I; // offset modes keep the pointer
  end

  // registered address outputs
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      EA_O            <= 16'h0000;
      PTR_NEXT_O      <= 16'h0000;
      PTR_WB_O        <= 1'b0;
      BITREV_ACTIVE_O <= 1'b0;
      MOD_WRAP_O      <= 1'b0;
    end else begin
      EA_O            <= ea_c;
      PTR_NEXT_O      <= ptr_c;
      PTR_WB_O        <= REQ_VALID_I && wb_c;
      BITREV_ACTIVE_O <= REQ_VALID_I && br_c;
      MOD_WRAP_O      <= REQ_VALID_I && wrap_c;
    end
  end

  // --------------------------------------------------------------------
  // program space address forming
  // --------------------------------------------------------------------
  logic [23:0] pa_c;
  logic        pv_c;
  logic        pcfg_c;
  logic        pref_c;

  // 24-bit program address from a 16-bit data address, or from the program counter for fetches
  always_comb begin
    pa_c   = 24'h000000;
    pv_c   = 1'b0;
    pcfg_c = 1'b0;
    pref_c = 1'b0;
    case (PACC_I)
      agb_pkg::AGB_PA_TBL: begin
        pa_c   = {table_page_q, PACC_EA_I};
        pcfg_c = table_page_q[`AGB_CFGSEL_BIT];
        pv_c   = 1'b1;
      end
      agb_pkg::AGB_PA_VIEW: begin
        if (PACC_EA_I[15] && VIEW_ON_I) begin
          if (PACC_WRITE_I) begin
            pref_c = 1'b1;
          end else begin
            pa_c = {1'b0, vispag_q, PACC_EA_I[14:0]};
            pv_c = 1'b1;
          end
        end
      end
      agb_pkg::AGB_PA_FETCH: begin
        pa_c = {1'b0, PC_I[22:1], 1'b0};
        pv_c = 1'b1;
      end
      default: ;
    endcase
  end

  // registered program address outputs
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      PROG_ADDR_O    <= 24'h000000;
      PROG_CFG_O     <= 1'b0;
      PROG_VALID_O   <= 1'b0;
      VIEW_REFUSED_O <= 1'b0;
    end else begin
      PROG_ADDR_O    <= pa_c;
      PROG_CFG_O     <= pcfg_c;
      PROG_VALID_O   <= pv_c;
      VIEW_REFUSED_O <= pref_c;
    end
  end

  // sticky refused-write status, set wins over a same-cycle clear
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I)
      view_ref_seen_q <= 1'b0;
    else if (pref_c)
      view_ref_seen_q <= 1'b1;
    else if (bs_q == agb_pkg::AGB_BS_DATA && bwr_q && baddr_q == `AGB_OFF_STATUS &&
             HWDATA_I[2])
      view_ref_seen_q <= 1'b0;
  end

  // program counter steps by two per program word
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I)
      PC_NEXT_O <= 23'h000000;
    else
      PC_NEXT_O <= PC_STEP_I ? 23'({PC_I[22:1], 1'b0} + 23'h000002) : PC_I;
  end

  // --------------------------------------------------------------------
  // table read data mapping
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      TRD_DATA_O <= 16'h0000;
    end else if (TRD_VALID_I) begin
      if (!TRD_HIGH_I)
        TRD_DATA_O <= !TRD_BYTE_I ? PROG_WORD_I[15:0] :
                      {8'h00, TRD_BSEL_I ? PROG_WORD_I[15:8] : PROG_WORD_I[7:0]};
      else
        TRD_DATA_O <= (TRD_BYTE_I && TRD_BSEL_I) ? 16'h0000 :
                      {8'h00, PROG_WORD_I[23:16]};
    end
  end

endmodule

`default_nettype wire

/* File: sim/agb_pmem_model.sv */
/*
  agb_pmem_model.sv: program memory seen by the table read path.
  assumes: combinational word lookup from the 24-bit program address.
*/
`timescale 1ns/10ps
`default_nettype none

module agb_pmem_model (
  input  wire logic [23:0] ADDR_I,
  output logic      [23:0] WORD_O
);
  // every byte lane of a word depends on the address, upper lane included
  assign WORD_O = {~ADDR_I[7:0], ADDR_I[15:0] ^ 16'h5aa5};
endmodule

`default_nettype wire

/* File: sim/agb_addr_gen_checker.sv */
/*
  agb_addr_gen_checker.sv: port assertions for the address generator.
  assumes: bound to agb_addr_gen; one clock, synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

module agb_addr_gen_checker (
  input wire logic        CLK_SYS_I,
  input wire logic        RST_N_I,
  input wire logic        REQ_VALID_I,
  input wire logic        REQ_X_SPACE_I,
  input wire logic        REQ_WRITE_I,
  input wire logic        REQ_BYTE_I,
  input wire logic [2:0]  REQ_MODE_I,
  input wire logic [3:0]  REQ_PTR_SEL_I,
  input wire logic [15:0] EA_O,
  input wire logic        PTR_WB_O,
  input wire logic        BITREV_ACTIVE_O,
  input wire logic        MOD_WRAP_O,
  input wire logic [1:0]  PACC_I,
  input wire logic [15:0] PACC_EA_I,
  input wire logic        PACC_WRITE_I,
  input wire logic        VIEW_ON_I,
  input wire logic [22:0] PC_I,
  input wire logic        PC_STEP_I,
  input wire logic [23:0] PROG_ADDR_O,
  input wire logic        PROG_CFG_O,
  input wire logic        PROG_VALID_O,
  input wire logic        VIEW_REFUSED_O,
  input wire logic [22:0] PC_NEXT_O,
  input wire logic        TRD_VALID_I,
  input wire logic        TRD_HIGH_I,
  input wire logic        TRD_BYTE_I,
  input wire logic [23:0] PROG_WORD_I,
  input wire logic [15:0] TRD_DATA_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  // ----------------------------------------------------------------
  // request shapes
  // ----------------------------------------------------------------
  sequence s_view_rd;
    PACC_I == 2'h2 && !PACC_WRITE_I && VIEW_ON_I && PACC_EA_I[15];
  endsequence
  sequence s_view_wr;
    PACC_I == 2'h2 && PACC_WRITE_I && VIEW_ON_I && PACC_EA_I[15];
  endsequence
  sequence s_trd_word;
    TRD_VALID_I && !TRD_HIGH_I && !TRD_BYTE_I;
  endsequence

  a_wb_prepost_only: assert property (
    !(REQ_MODE_I inside {3'h2, 3'h3, 3'h4, 3'h5}) |=> !PTR_WB_O)
    else $error("pointer write back outside pre or post modify");
  a_brev_xwr_only: assert property (
    !(REQ_VALID_I && REQ_X_SPACE_I && REQ_WRITE_I && !REQ_BYTE_I) |=> !BITREV_ACTIVE_O)
    else $error("bit reversal outside x word writes");
  a_brev_mode_gate: assert property (
    REQ_PTR_SEL_I == 4'hf || !(REQ_MODE_I inside {3'h2, 3'h4}) |=> !BITREV_ACTIVE_O)
    else $error("bit reversal with wrong mode or select");
  a_brev_word_ea: assert property (
    BITREV_ACTIVE_O |-> !EA_O[0])
    else $error("bit reversed address not word aligned");
  a_brev_beats_mod: assert property (
    BITREV_ACTIVE_O |-> !MOD_WRAP_O)
    else $error("modulo wrap during bit reversed write");
  a_tbl_addr_form: assert property (
    PACC_I == 2'h1 |=> PROG_ADDR_O[15:0] == $past(PACC_EA_I) && PROG_CFG_O == PROG_ADDR_O[23])
    else $error("table address forming wrong");
  a_view_addr_form: assert property (
    s_view_rd |=> PROG_ADDR_O[23] == 1'b0 && PROG_ADDR_O[14:0] == $past(PACC_EA_I[14:0]))
    else $error("view address forming wrong");
  a_view_read_only: assert property (
    s_view_wr |=> VIEW_REFUSED_O && !PROG_VALID_O)
    else $error("view write not refused");
  a_pc_step_two: assert property (
    PC_STEP_I |=> PC_NEXT_O == {$past(PC_I[22:1]), 1'b0} + 23'h000002)
    else $error("program counter step wrong");
  a_trd_low_word: assert property (
    s_trd_word |=> TRD_DATA_O == $past(PROG_WORD_I[15:0]))
    else $error("low word table read wrong");
  a_trd_phantom_zero: assert property (
    TRD_VALID_I && TRD_HIGH_I |=> TRD_DATA_O[15:8] == 8'h00)
    else $error("phantom byte not zero");
endmodule

bind agb_addr_gen agb_addr_gen_checker i_agb_addr_gen_checker (.*);

`default_nettype wire

/* File: sim/tb_top.sv */
/*
  tb_top.sv: self-checking bench for the address generator.
  assumes: ahb-lite master tasks, program memory model on the table path.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic        CLK_SYS_I, RST_N_I, HSEL_I, HWRITE_I, REQ_VALID_I, REQ_X_SPACE_I, REQ_WRITE_I;
  logic        REQ_BYTE_I, PACC_WRITE_I, VIEW_ON_I, PC_STEP_I, TRD_VALID_I, TRD_HIGH_I;
  logic        TRD_BYTE_I, TRD_BSEL_I, HREADYOUT_O, HRESP_O, PTR_WB_O, BITREV_ACTIVE_O;
  logic        MOD_WRAP_O, PROG_CFG_O, PROG_VALID_O, VIEW_REFUSED_O;
  logic [1:0]  HTRANS_I, PACC_I;
  logic [2:0]  HSIZE_I, REQ_MODE_I;
  logic [3:0]  REQ_PTR_SEL_I;
  logic [15:0] REQ_PTR_I, REQ_OFFSET_I, MOD_START_I, MOD_END_I, EA_O, PTR_NEXT_O, p;
  logic [15:0] PACC_EA_I, TRD_DATA_O;
  logic [22:0] PC_I, PC_NEXT_O;
  logic [23:0] PROG_ADDR_O, PROG_WORD_I;
  logic [31:0] HADDR_I, HWDATA_I, HRDATA_O, rd_q;
  wire  logic  HREADY_I = HREADYOUT_O;
  int          failures, check_count;
  logic [31:0] rst_exp [4] = '{32'h00000fff, 32'h0, 32'h0, 32'h0};
  logic [5:0]  plain [4] = '{6'b111010, 6'b100010, 6'b010010, 6'b110011};
  logic [18:0] trd [6] = '{{3'b000, 16'he44a}, {3'b011, 16'h00e4}, {3'b010, 16'h004a},
                           {3'b100, 16'h0010}, {3'b110, 16'h0010}, {3'b111, 16'h0000}};

  agb_addr_gen   i_agb_addr_gen (.*);
  agb_pmem_model i_agb_pmem_model (.ADDR_I(PROG_ADDR_O), .WORD_O(PROG_WORD_I));

  // free-running 100 MHz clock
  initial begin
    CLK_SYS_I = 1'b0;
    forever #5 CLK_SYS_I = ~CLK_SYS_I;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // waits for the edge that samples hready high, takes read data there
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge CLK_SYS_I);
    while (HREADYOUT_O !== 1'b1 && n < 50) begin
      @(posedge CLK_SYS_I);
      n++;
    end
    if (n == 50) begin
      failures++;
      give_verdict();
    end
    rd_q = HRDATA_O;
    chk(HRESP_O, 1'b0);
  endtask

  // one single word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    HSEL_I <= 1'b1;
    HTRANS_I <= 2'h2;
    HADDR_I <= a;
    HWRITE_I <= wr;
    wait_rdy();
    HSEL_I <= 1'b0;
    HTRANS_I <= 2'h0;
    HWDATA_I <= d;
    wait_rdy();
  endtask

  task automatic req(input logic [5:0] k, input logic [15:0] ptr, input logic [15:0] ofs);
    REQ_VALID_I <= 1'b1;
    {REQ_X_SPACE_I, REQ_WRITE_I, REQ_BYTE_I, REQ_MODE_I} <= k;
    REQ_PTR_I <= ptr;
    REQ_OFFSET_I <= ofs;
    @(posedge CLK_SYS_I);
    #1;
  endtask

  task automatic pacc(input logic [1:0] k, input logic w, input logic [15:0] ea);
    PACC_I <= k;
    PACC_WRITE_I <= w;
    PACC_EA_I <= ea;
    @(posedge CLK_SYS_I);
    #1;
  endtask

  function automatic logic [3:0] rev4(input logic [3:0] v);
    return {v[0], v[1], v[2], v[3]};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    check_count = 0;
    {RST_N_I, HSEL_I, HWRITE_I, HTRANS_I, HADDR_I, HWDATA_I} = '0;
    {REQ_VALID_I, REQ_X_SPACE_I, REQ_WRITE_I, REQ_BYTE_I, REQ_MODE_I} = '0;
    {REQ_PTR_I, REQ_OFFSET_I, PACC_I, PACC_WRITE_I, PACC_EA_I, PC_I, PC_STEP_I} = '0;
    {TRD_VALID_I, TRD_HIGH_I, TRD_BYTE_I, TRD_BSEL_I} = '0;
    HSIZE_I = 3'h2;
    VIEW_ON_I = 1'b1;
    REQ_PTR_SEL_I = 4'h3;
    MOD_START_I = 16'h1000;
    MOD_END_I = 16'h101f;
    repeat (6) @(posedge CLK_SYS_I);
    RST_N_I <= 1'b1;
    @(posedge CLK_SYS_I);
    #1;
    // reset values, modifier width, unmapped place
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, 32'(4 * i), 32'h0);
      chk(rd_q, rst_exp[i]);
    end
    ahb(1'b1, 32'h04, 32'hffffffff);
    ahb(1'b0, 32'h04, 32'h0);
    chk(rd_q, 32'h0000ffff);
    ahb(1'b1, 32'h20, 32'h12345678);
    ahb(1'b0, 32'h20, 32'h0);
    chk(rd_q, 32'h0);
    // bit reversed walk over a 16-entry word buffer
    ahb(1'b1, 32'h00, 32'h03ff);
    ahb(1'b1, 32'h04, 32'h8008);
    p = 16'h1000;
    for (int i = 0; i < 16; i++) begin
      req(6'b110010, p, 16'h0);
      chk(EA_O, 16'h1000 + {11'h0, rev4(4'(i)), 1'b0});
      chk(BITREV_ACTIVE_O, 1'b1);
      chk(PTR_NEXT_O, 16'h1000 + {11'h0, rev4(4'(i + 1)), 1'b0});
      chk(PTR_WB_O, 1'b1);
      p = PTR_NEXT_O;
    end
    req(6'b110100, 16'h1000, 16'h0);
    chk(EA_O, 16'h1010);
    // byte write, x read, y write, post-decrement get plain addresses
    for (int i = 0; i < 4; i++) begin
      req(plain[i], 16'h1004, 16'h0);
      chk(BITREV_ACTIVE_O, 1'b0);
      chk(EA_O, 16'h1004);
    end
    req(6'b010101, 16'h1004, 16'h0);
    chk({EA_O, PTR_WB_O}, 17'h02005);
    req(6'b100111, 16'h2000, 16'h0010);
    chk({EA_O, PTR_WB_O}, 17'h04020);
    // modulo on x, bit reversal also enabled
    ahb(1'b1, 32'h00, 32'h83f3);
    req(6'b100010, 16'h101e, 16'h0);
    chk(MOD_WRAP_O, 1'b1);
    chk(PTR_NEXT_O, 16'h1000);
    req(6'b100110, 16'h101c, 16'h0006);
    chk(EA_O, 16'h1002);
    chk(PTR_WB_O, 1'b0);
    req(6'b110010, 16'h101e, 16'h0);
    chk({BITREV_ACTIVE_O, MOD_WRAP_O}, 2'b10);
    req(6'b000010, 16'h101e, 16'h0);
    chk({MOD_WRAP_O, PTR_NEXT_O}, 17'h01020);
    // table addresses and table read mapping
    ahb(1'b1, 32'h08, 32'h85);
    pacc(2'h1, 1'b0, 16'hbeef);
    chk(PROG_ADDR_O, 24'h85beef);
    chk(PROG_CFG_O, 1'b1);
    for (int i = 0; i < 6; i++) begin
      TRD_VALID_I <= 1'b1;
      {TRD_HIGH_I, TRD_BYTE_I, TRD_BSEL_I} <= trd[i][18:16];
      @(posedge CLK_SYS_I);
      #1;
      chk(TRD_DATA_O, trd[i][15:0]);
    end
    ahb(1'b1, 32'h08, 32'h05);
    pacc(2'h1, 1'b0, 16'hbeef);
    chk(PROG_CFG_O, 1'b0);
    // view reads, refused view writes, sticky status
    ahb(1'b1, 32'h0c, 32'h0b);
    pacc(2'h2, 1'b0, 16'h9234);
    chk(PROG_ADDR_O, 24'h059234);
    chk(PROG_VALID_O, 1'b1);
    pacc(2'h2, 1'b1, 16'h9234);
    chk({VIEW_REFUSED_O, PROG_VALID_O}, 2'b10);
    pacc(2'h0, 1'b0, 16'h0);
    ahb(1'b0, 32'h10, 32'h0);
    chk(rd_q & 32'h4, 32'h4);
    ahb(1'b1, 32'h10, 32'h4);
    ahb(1'b0, 32'h10, 32'h0);
    chk(rd_q & 32'h4, 32'h0);
    VIEW_ON_I <= 1'b0;
    pacc(2'h2, 1'b0, 16'h9234);
    chk(PROG_VALID_O, 1'b0);
    // program counter step
    PC_I <= 23'h000101;
    PC_STEP_I <= 1'b1;
    @(posedge CLK_SYS_I);
    #1;
    chk(PC_NEXT_O, 23'h000102);
    PC_STEP_I <= 1'b0;
    pacc(2'h3, 1'b0, 16'h0);
    chk(PC_NEXT_O, 23'h000101);
    chk(PROG_ADDR_O, 24'h000100);
    give_verdict();
  end
endmodule

`default_nettype wire
